// ### video_out_pixel_processing.sv
// Pixel stage: format conversion, 2x upscaling, overlay keying/blending.
// Assumes an upstream fetch path delivering pairs per line and an
// overlay stream already at output resolution; all on clk.
//
// Contract
// - interspersed unscaled chroma uses -1,5,13,-1 /16
// - 4:2:0 reuses stored chroma line, then converts
// - upscaling doubles horizontally only, no vertical
// - upscaled luma copies or uses -3,19,19,-3 /32
// - co-sited chroma copies or uses same /32 filter
// - interspersed upscaled chroma uses 13,5 and 5,13
// - filter edges mirror first and last pixels
// - edge tap orders follow mirrored input indices
// - modes 0-2 unscaled, 4-6 upscaled, 3/7 reserved
// - mode 8 streams, 9 messages, above reserved
// - overlay merge bit decides overlay presence
// - fine blending needs both bits, else 25% steps
// - U/V least bits pick alpha zero or one
// - U alpha covers U,V,Y0; V alpha only Y1
// - alpha bit 7 set outputs overlay unchanged
// - blend is image plus level times difference >>7
// - keying needs enhanced and key enable bits
// - masked match drops overlay, video shows through
// - luma ignore count masks zero to four bits
// - chroma ignore count masks U and V bits
// - blending and keying may run together
//
// Our own choices: the placing of the registers and the plain strobed port.
module video_out_pixel_processing (
  input  wire logic                 clk,          // 40 MHz clock
  input  wire logic                 rst_n,        // Sync reset
  input  wire logic [7:0]           addr,         // Register byte address
  input  wire logic [31:0]          wdata,        // Write data
  input  wire logic                 wr,           // Write strobe
  input  wire logic                 rd,           // Read strobe
  output logic [31:0]               rdata,        // Read data, next cycle
  input  wire logic                 in_valid,     // Video pair offered
  input  video_out_pkg::vin_t       in_data,      // Video pair
  output logic                      in_ready,     // Video pair taken
  input  wire logic                 ovl_valid,    // Overlay pair offered
  input  video_out_pkg::pair_t      ovl_data,     // Overlay pair
  output logic                      ovl_ready,    // Overlay pair taken
  output logic                      out_valid,    // Output pair strobe
  output video_out_pkg::pair_t      out_data,     // Co-sited 4:2:2 pair
  input  wire logic                 raw_in_valid, // Raw byte offered
  input  wire logic [7:0]           raw_in,       // Raw byte
  output logic                      raw_out_valid,// Raw byte strobe
  output logic [7:0]                raw_out       // Raw byte out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    video_out_pkg::state_t st;
    video_out_pkg::cnt_t   n;      // Luma samples in line
    video_out_pkg::cnt_t   j;      // Output pair index
    logic [3:0]            mode;
    logic                  merge;
    logic                  enh;
    logic                  fine;
    logic                  keyen;
    logic [7:0]            alpha0;
    logic [7:0]            alpha1;
    logic [7:0]            ky;
    logic [7:0]            ku;
    logic [7:0]            kv;
    logic [2:0]            my;
    logic [2:0]            mc;
    logic                  in_ready;
    logic                  ovl_ready;
    logic                  out_valid;
    video_out_pkg::pair_t  out;
    logic [31:0]           rdata;
    logic                  raw_v;
    logic [7:0]            raw;
  } state_s_t;

  state_s_t s_reg;
  state_s_t s_next;

  // Line stores; chroma survives across lines for 4:2:0 reuse
  logic [7:0] y_mem [0:video_out_pkg::LINE_MAX-1];
  logic [7:0] u_mem [0:video_out_pkg::CHROMA_MAX-1];
  logic [7:0] v_mem [0:video_out_pkg::CHROMA_MAX-1];

  logic in_take;
  logic out_step;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mirror an index at both line ends
  function automatic int mir(input int idx, input int n);
    int k;
    k = idx;
    if (k < 0) begin
      k = -k - 1;
    end
    if (k >= n) begin
      k = 2 * n - 1 - k;
    end
    if (k < 0) begin
      k = 0;
    end
    return k;
  endfunction : mir

  // Four-tap filter with rounding and clamp to a byte
  function automatic logic [7:0] filt(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] c, input logic [7:0] d,
                                      input int w0, input int w1, input int w2,
                                      input int w3, input int sh);
    int s;
    s = int'(a) * w0 + int'(b) * w1 + int'(c) * w2 + int'(d) * w3;
    s = (s + (1 <<< (sh - 1))) >>> sh;
    if (s < 0) begin
      s = 0;
    end else if (s > 255) begin
      s = 255;
    end
    return 8'(s);
  endfunction : filt

  // Blend one sample by an 8-bit alpha
  function automatic logic [7:0] blend(input logic [7:0] img, input logic [7:0] ovl,
                                       input logic [7:0] alpha, input logic fine);
    int lvl;
    int d;
    lvl = 0;
    d = int'(ovl) - int'(img);
    if (alpha[7]) begin
      return ovl;
    end
    if (fine) begin
      lvl = int'(alpha[6:0]);
    end else begin
      lvl = int'({alpha[6:5], 5'h00});
    end
    return 8'(int'(img) + ((lvl * d) >>> 7));
  endfunction : blend

  // Compare with low bits ignored
  function automatic logic hit(input logic [7:0] val, input logic [7:0] key,
                               input logic [2:0] cnt);
    logic [2:0] c;
    logic [7:0] m;
    c = (cnt > video_out_pkg::IGN_LIMIT) ? video_out_pkg::IGN_LIMIT : cnt;
    m = 8'hff << c;
    return ((val ^ key) & m) == 8'h00;
  endfunction : hit

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       video;
    logic       up;
    logic       cosited;
    logic       merge_on;
    logic       key_on;
    logic       fine_on;
    logic       last;
    logic       cp;
    logic       k0;
    logic       k1;
    logic [7:0] a0;
    logic [7:0] a1;
    int         n;
    int         cw;
    int         j;
    int         i;
    int         b;
    int         w0;
    int         w1;
    int         w2;
    int         w3;
    int         sh;
    video_out_pkg::pair_t img;
    video_out_pkg::pair_t mix;
    s_next   = s_reg;
    video    = (s_reg.mode[3] == 1'b0) && (s_reg.mode[1:0] != 2'h3);
    up       = s_reg.mode[2];
    cosited  = (s_reg.mode[1:0] == 2'h0);
    merge_on = video && s_reg.merge;
    key_on   = s_reg.enh && s_reg.keyen;
    fine_on  = s_reg.enh && s_reg.fine;
    n        = int'(s_reg.n);
    cw       = n / 2;
    j        = int'(s_reg.j);
    i        = 0;
    b        = 0;
    cp       = 1'b0;
    w0       = 0;
    w1       = 0;
    w2       = 0;
    w3       = 0;
    sh       = 1;
    img      = '0;
    mix      = '0;

    // Register port; a read answers in the next cycle only
    s_next.rdata = 32'h0000_0000;
    if (wr) begin
      if (addr == video_out_pkg::VIDEO_OUT_CONTROL_OFS) begin
        s_next.mode  = wdata[video_out_pkg::MODE_LSB +: 4];
        s_next.merge = wdata[video_out_pkg::MERGE_BIT];
      end else if (addr == video_out_pkg::ENHANCED_CONTROL_OFS) begin
        s_next.enh   = wdata[video_out_pkg::ENH_BIT];
        s_next.fine  = wdata[video_out_pkg::FINE_BIT];
        s_next.keyen = wdata[video_out_pkg::KEY_BIT];
      end else if (addr == video_out_pkg::ALPHA_LEVELS_OFS) begin
        s_next.alpha0 = wdata[7:0];
        s_next.alpha1 = wdata[video_out_pkg::ALPHA_ONE_LSB +: 8];
      end else if (addr == video_out_pkg::TRANSPARENCY_MATCH_VALUE_OFS) begin
        s_next.ky = wdata[7:0];
        s_next.ku = wdata[video_out_pkg::KEY_U_LSB +: 8];
        s_next.kv = wdata[video_out_pkg::KEY_V_LSB +: 8];
      end else if (addr == video_out_pkg::MATCH_IGNORE_BITS_OFS) begin
        s_next.my = wdata[2:0];
        s_next.mc = wdata[video_out_pkg::CHROMA_IGN_LSB +: 3];
      end
    end
    if (rd) begin
      if (addr == video_out_pkg::VIDEO_OUT_CONTROL_OFS) begin
        s_next.rdata[video_out_pkg::MODE_LSB +: 4]  = s_reg.mode;
        s_next.rdata[video_out_pkg::MERGE_BIT]      = s_reg.merge;
      end else if (addr == video_out_pkg::ENHANCED_CONTROL_OFS) begin
        s_next.rdata[video_out_pkg::ENH_BIT]  = s_reg.enh;
        s_next.rdata[video_out_pkg::FINE_BIT] = s_reg.fine;
        s_next.rdata[video_out_pkg::KEY_BIT]  = s_reg.keyen;
      end else if (addr == video_out_pkg::ALPHA_LEVELS_OFS) begin
        s_next.rdata[15:0] = {s_reg.alpha1, s_reg.alpha0};
      end else if (addr == video_out_pkg::TRANSPARENCY_MATCH_VALUE_OFS) begin
        s_next.rdata[23:0] = {s_reg.kv, s_reg.ku, s_reg.ky};
      end else if (addr == video_out_pkg::MATCH_IGNORE_BITS_OFS) begin
        s_next.rdata[2:0] = s_reg.my;
        s_next.rdata[video_out_pkg::CHROMA_IGN_LSB +: 3] = s_reg.mc;
      end else if (addr == video_out_pkg::STATUS_OFS) begin
        s_next.rdata[0] = (s_reg.st == video_out_pkg::ST_OUT);
        s_next.rdata[video_out_pkg::STAT_MODE_LSB +: 4]  = s_reg.mode;
        s_next.rdata[video_out_pkg::STAT_WIDTH_LSB +: 11] = s_reg.n;
      end
    end

    // Raw bytes pass untouched in the data-transfer modes
    s_next.raw_v = raw_in_valid && ((s_reg.mode == video_out_pkg::MODE_STREAM) ||
                                    (s_reg.mode == video_out_pkg::MODE_MESSAGE));
    s_next.raw   = raw_in;

    // Luma: unscaled takes two samples, upscaled copies one and filters one over four taps
    if (up) begin
      img.y0 = y_mem[mir(j, n)];
      img.y1 = filt(y_mem[mir(j - 1, n)], y_mem[mir(j, n)],
                    y_mem[mir(j + 1, n)], y_mem[mir(j + 2, n)],
                    -3, 19, 19, -3, 5);
    end else begin
      img.y0 = y_mem[mir(2 * j, n)];
      img.y1 = y_mem[mir(2 * j + 1, n)];
    end

    // Chroma tap choice; the 4:2:0 line store is simply reread
    i = up ? j / 2 : j;
    if (!up) begin
      cp = cosited;
      b  = i - 2;
      w0 = -1; w1 = 5; w2 = 13; w3 = -1; sh = 4;
    end else if (j % 2 == 0) begin
      cp = cosited;
      b  = i - 2;
      w0 = -1; w1 = 5; w2 = 13; w3 = -1; sh = 4;
    end else if (cosited) begin
      b  = i - 1;
      w0 = -3; w1 = 19; w2 = 19; w3 = -3; sh = 5;
    end else begin
      b  = i - 1;
      w0 = -1; w1 = 13; w2 = 5; w3 = -1; sh = 4;
    end
    if (cp) begin
      img.u = u_mem[mir(i, cw)];
      img.v = v_mem[mir(i, cw)];
    end else begin
      img.u = filt(u_mem[mir(b, cw)], u_mem[mir(b + 1, cw)], u_mem[mir(b + 2, cw)],
                   u_mem[mir(b + 3, cw)], w0, w1, w2, w3, sh);
      img.v = filt(v_mem[mir(b, cw)], v_mem[mir(b + 1, cw)], v_mem[mir(b + 2, cw)],
                   v_mem[mir(b + 3, cw)], w0, w1, w2, w3, sh);
    end

    // Overlay: key first so a keyed pixel ignores its alpha
    a0 = ovl_data.u[0] ? s_reg.alpha1 : s_reg.alpha0;
    a1 = ovl_data.v[0] ? s_reg.alpha1 : s_reg.alpha0;
    k0 = key_on && hit(ovl_data.y0, s_reg.ky, s_reg.my) &&
         hit(ovl_data.u, s_reg.ku, s_reg.mc) && hit(ovl_data.v, s_reg.kv, s_reg.mc);
    k1 = key_on && hit(ovl_data.y1, s_reg.ky, s_reg.my) &&
         hit(ovl_data.u, s_reg.ku, s_reg.mc) && hit(ovl_data.v, s_reg.kv, s_reg.mc);
    mix = img;
    if (merge_on) begin
      if (!k0) begin
        mix.y0 = blend(img.y0, ovl_data.y0, a0, fine_on);
        mix.u  = blend(img.u, ovl_data.u, a0, fine_on);
        mix.v  = blend(img.v, ovl_data.v, a0, fine_on);
      end
      if (!k1) begin
        mix.y1 = blend(img.y1, ovl_data.y1, a1, fine_on);
      end
    end

    // Line sequencing: load a line, then emit its output pairs
    last             = up ? (j + 1 >= n) : (j + 1 >= cw);
    s_next.out_valid = 1'b0;
    case (s_reg.st)
      video_out_pkg::ST_LOAD: begin
        if (in_take) begin
          s_next.n = s_reg.n + 11'h002;
          if (in_data.eol) begin
            s_next.st = video_out_pkg::ST_OUT;
            s_next.j  = '0;
          end
        end
      end
      video_out_pkg::ST_OUT: begin
        if (out_step) begin
          s_next.out_valid = 1'b1;
          s_next.out       = mix;
          s_next.j         = s_reg.j + 11'h001;
          if (last) begin
            s_next.st = video_out_pkg::ST_LOAD;
            s_next.n  = '0;
          end
        end
      end
      default: begin
        s_next.st = video_out_pkg::ST_LOAD;
      end
    endcase
    s_next.in_ready  = (s_next.st == video_out_pkg::ST_LOAD) && video &&
                       (s_next.n < 11'(video_out_pkg::LINE_MAX));
    s_next.ovl_ready = (s_next.st == video_out_pkg::ST_OUT) && merge_on &&
                       !(out_step && last);
  end

  // Handshakes seen by the sequencer and the line stores
  assign in_take  = in_valid && s_reg.in_ready;
  assign out_step = (s_reg.st == video_out_pkg::ST_OUT) &&
                    (!(s_reg.merge && s_reg.mode[3] == 1'b0) ||
                     (ovl_valid && s_reg.ovl_ready));

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_reg        <= '0;
      s_reg.st     <= video_out_pkg::ST_LOAD;
      s_reg.mode   <= video_out_pkg::MODE_RESET;
      s_reg.alpha0 <= video_out_pkg::ALPHA_RESET;
      s_reg.alpha1 <= video_out_pkg::ALPHA_RESET;
      s_reg.ky     <= video_out_pkg::KEY_RESET;
      s_reg.ku     <= video_out_pkg::KEY_RESET;
      s_reg.kv     <= video_out_pkg::KEY_RESET;
      s_reg.my     <= video_out_pkg::IGN_RESET;
      s_reg.mc     <= video_out_pkg::IGN_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // Line stores; chroma keeps its old line unless marked fresh
  always_ff @(posedge clk) begin
    if (in_take) begin
      y_mem[s_reg.n[9:0]]         <= in_data.px.y0;
      y_mem[s_reg.n[9:0] + 10'h1] <= in_data.px.y1;
      if (in_data.chroma_new) begin
        u_mem[s_reg.n[9:1]] <= in_data.px.u;
        v_mem[s_reg.n[9:1]] <= in_data.px.v;
      end
    end
  end

  assign rdata         = s_reg.rdata;
  assign in_ready      = s_reg.in_ready;
  assign ovl_ready     = s_reg.ovl_ready;
  assign out_valid     = s_reg.out_valid;
  assign out_data      = s_reg.out;
  assign raw_out_valid = s_reg.raw_v;
  assign raw_out       = s_reg.raw;

endmodule : video_out_pixel_processing

// ### video_out_pkg.sv
// Shared constants and types of the video output pixel-processing stage.
// Assumes one 40 MHz clock domain and a plain register port.
package video_out_pkg;

  // ----------------------------------------------------------------
  // Sizes and clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;   // 40 MHz
  localparam int LINE_MAX      = 1024; // Luma samples a line holds
  localparam int CHROMA_MAX    = LINE_MAX / 2;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] VIDEO_OUT_CONTROL_OFS        = 8'h00;
  localparam logic [7:0] ENHANCED_CONTROL_OFS         = 8'h04;
  localparam logic [7:0] ALPHA_LEVELS_OFS             = 8'h08;
  localparam logic [7:0] TRANSPARENCY_MATCH_VALUE_OFS = 8'h0c;
  localparam logic [7:0] MATCH_IGNORE_BITS_OFS        = 8'h10;
  localparam logic [7:0] STATUS_OFS                   = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_LSB        = 0;  // video_out_control[3:0]
  localparam int MERGE_BIT       = 4;  // overlay_merge_on
  localparam int ENH_BIT         = 0;  // enhanced_features_on
  localparam int FINE_BIT        = 1;  // fine blending
  localparam int KEY_BIT         = 2;  // transparency keying on
  localparam int ALPHA_ONE_LSB   = 8;  // alpha_zero sits in [7:0]
  localparam int KEY_U_LSB       = 8;  // key Y in [7:0]
  localparam int KEY_V_LSB       = 16;
  localparam int CHROMA_IGN_LSB  = 4;  // luma ignore count in [2:0]
  localparam int STAT_WIDTH_LSB  = 8;  // busy in bit 0, mode [7:4]
  localparam int STAT_MODE_LSB   = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_RESET  = 4'h0;
  localparam logic [7:0] ALPHA_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET   = 8'h00;
  localparam logic [2:0] IGN_RESET   = 3'h0;
  localparam logic [2:0] IGN_LIMIT   = 3'h4; // Counts above four clamp

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_422C_1X = 4'h0;
  localparam logic [3:0] MODE_422I_1X = 4'h1;
  localparam logic [3:0] MODE_420_1X  = 4'h2;
  localparam logic [3:0] MODE_422C_2X = 4'h4;
  localparam logic [3:0] MODE_422I_2X = 4'h5;
  localparam logic [3:0] MODE_420_2X  = 4'h6;
  localparam logic [3:0] MODE_STREAM  = 4'h8;
  localparam logic [3:0] MODE_MESSAGE = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [10:0] cnt_t;

  typedef struct packed {
    logic [7:0] y0;
    logic [7:0] y1;
    logic [7:0] u;
    logic [7:0] v;
  } pair_t;

  typedef struct packed {
    pair_t px;          // Two luma samples and one chroma pair
    logic  chroma_new;  // Chroma bytes are fresh for this line
    logic  eol;         // Last pair of the line
  } vin_t;

  typedef enum logic {ST_LOAD, ST_OUT} state_t;

endpackage : video_out_pkg

// ### video_out_monitor.sv
// Port assertions for the pixel stage.
// Assumes a bind into video_out_pixel_processing; one clock, sync reset.
module video_out_monitor (
  input wire logic            clk,           // Clock
  input wire logic            rst_n,         // Sync reset
  input wire logic [7:0]      addr,          // Address
  input wire logic [31:0]     wdata,         // Write data
  input wire logic            wr,            // Write strobe
  input wire logic            rd,            // Read strobe
  input wire logic [31:0]     rdata,         // Read data
  input wire logic            in_valid,      // Video offer
  input video_out_pkg::vin_t  in_data,       // Video pair
  input wire logic            in_ready,      // Video taken
  input wire logic            ovl_valid,     // Overlay offer
  input video_out_pkg::pair_t ovl_data,      // Overlay pair
  input wire logic            ovl_ready,     // Overlay taken
  input wire logic            out_valid,     // Output strobe
  input video_out_pkg::pair_t out_data,      // Output pair
  input wire logic            raw_in_valid,  // Raw offer
  input wire logic [7:0]      raw_in,        // Raw byte
  input wire logic            raw_out_valid, // Raw strobe
  input wire logic [7:0]      raw_out        // Raw out
);
  // ------------------------------------------------------------
  // Register shadows
  // ------------------------------------------------------------
  logic [4:0]  ctl_reg;
  logic [2:0]  enh_reg;
  logic [15:0] alpha_reg;
  logic        rsv, raw_mode, opaque;

  // Shadows follow bus writes so checks know the active mode
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_reg   <= 5'h00;
      enh_reg   <= 3'h0;
      alpha_reg <= 16'h0000;
    end else if (wr) begin
      if (addr == 8'h00) ctl_reg <= wdata[4:0];
      if (addr == 8'h04) enh_reg <= wdata[2:0];
      if (addr == 8'h08) alpha_reg <= wdata[15:0];
    end
  end

  // Mode classes; opaque means both alphas select pure overlay
  assign rsv      = (ctl_reg[1:0] == 2'b11) || ctl_reg[3];
  assign raw_mode = ctl_reg[3:1] == 3'b100;
  assign opaque   = ctl_reg[4] && !ctl_reg[3] && !(enh_reg[0] && enh_reg[2])
                    && alpha_reg[7] && alpha_reg[15];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_read_slot: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside its slot");
  a_raw_echo: assert property (
    raw_out_valid |-> $past(raw_in_valid) && raw_out == $past(raw_in))
    else $error("raw byte not echoed");
  a_raw_mode: assert property (raw_out_valid |-> raw_mode || $past(raw_mode))
    else $error("raw byte outside raw modes");
  a_reserved_idle: assert property (
    rsv && $past(rsv) && $past(rsv, 2) |-> !in_ready)
    else $error("intake open in reserved mode");
  a_eol_stops: assert property (in_valid && in_ready && in_data.eol |=> !in_ready)
    else $error("intake open after line end");
  a_out_after_load: assert property (out_valid |-> !$past(in_ready))
    else $error("output during intake");
  a_merge_gate: assert property (ovl_ready |-> ctl_reg[4] || $past(ctl_reg[4]))
    else $error("overlay taken without merge");
  a_opaque_copy: assert property (
    opaque && ovl_valid && ovl_ready |=> out_valid && out_data == $past(ovl_data))
    else $error("opaque overlay not copied");
endmodule : video_out_monitor

bind video_out_pixel_processing video_out_monitor i_video_out_monitor (.clk, .rst_n,
  .addr, .wdata, .wr, .rd, .rdata, .in_valid, .in_data, .in_ready, .ovl_valid, .ovl_data,
  .ovl_ready, .out_valid, .out_data, .raw_in_valid, .raw_in, .raw_out_valid, .raw_out);

// ### video_out_sink.sv
// Model of the downstream encoder that collects output pairs.
// Assumes out_data stands between strobes; never stalls the stage.
module video_out_sink (
  input wire logic            clk,       // Clock
  input wire logic            out_valid, // Pair strobe
  input video_out_pkg::pair_t out_data   // Pair
);
  video_out_pkg::pair_t got_q[$]; // Pairs seen, oldest first

  // Sample mid-cycle so the launching edge has settled
  always @(negedge clk) begin
    if (out_valid === 1'b1) got_q.push_back(out_data);
  end
endmodule : video_out_sink

// ### test_video_out_pixel_processing.sv
// Self-checking bench for the pixel stage.
// Assumes the package, the design, its monitor and the sink model.
module test_video_out_pixel_processing;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, wr, rd, in_valid, ovl_valid, raw_in_valid;
  logic in_ready, ovl_ready, out_valid, raw_out_valid;
  logic [7:0] addr, raw_in, raw_out;
  logic [31:0] wdata, rdata;
  video_out_pkg::vin_t in_data;
  video_out_pkg::pair_t ovl_data, out_data, lin[2];
  int n_mismatch, tests_run;
  logic [2:0] enh_t[4] = '{3'h0, 3'h3, 3'h4, 3'h7};
  logic [15:0] al_t[4] = '{16'h2050, 16'h2050, 16'hff80, 16'h2050};

  video_out_pixel_processing i_video_out_pixel_processing (.clk, .rst_n, .addr, .wdata,
    .wr, .rd, .rdata, .in_valid, .in_data, .in_ready, .ovl_valid, .ovl_data, .ovl_ready,
    .out_valid, .out_data, .raw_in_valid, .raw_in, .raw_out_valid, .raw_out);
  video_out_sink i_video_out_sink (.clk, .out_valid, .out_data);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task end_of_test;
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  task hang;
    n_mismatch++;
    end_of_test();
  endtask : hang

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Bus cycles: one-cycle strobes, read data in the following cycle
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  task rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rreg

  // Two whole pairs a line keep the width even; held until taken
  task send_line;
    int t;
    for (int i = 0; i < 2; i++) begin
      in_valid <= 1'b1;
      in_data  <= '{lin[i], 1'b1, i == 1};
      t = 0;
      do begin
        @(negedge clk);
        t++;
      end while (in_ready !== 1'b1 && t < 300);
      if (in_ready !== 1'b1) hang();
      @(posedge clk);
    end
    in_valid <= 1'b0;
  endtask : send_line

  task take(input video_out_pkg::pair_t e, input logic [31:0] m);
    for (int t = 0; t < 300 && i_video_out_sink.got_q.size() == 0; t++) @(negedge clk);
    if (i_video_out_sink.got_q.size() == 0) hang();
    chk(i_video_out_sink.got_q.pop_front() & m, e & m);
  endtask : take

  function automatic int mi(int k, int n);
    return k < 0 ? 0 : (k >= n ? 2 * n - 1 - k : k);
  endfunction : mi

  // Inserted sample, rounded half up; edges mirrored
  function automatic logic [7:0] ip(int s[$], int k);
    int n, r;
    n = s.size();
    r = (-3 * s[mi(k - 1, n)] + 19 * s[k] + 19 * s[mi(k + 1, n)] - 3 * s[mi(k + 2, n)] + 16) >>> 5;
    return r < 0 ? 8'h00 : (r > 255 ? 8'hff : 8'(r));
  endfunction : ip

  // Coarse blending keeps only the top two level bits
  function automatic logic [7:0] bl(int i, int o, logic [7:0] a, logic f);
    int lv;
    lv = f ? a[6:0] : {a[6:5], 5'b0};
    return a[7] ? 8'(o) : 8'(i + ((lv * (o - i)) >>> 7));
  endfunction : bl

  task t_regs;
    rreg(8'h00, 32'h0);
    rreg(8'h18, 32'h0);
    wreg(8'h08, 32'h0000_a55a);
    rreg(8'h08, 32'h0000_a55a);
  endtask : t_regs

  // Every video mode; interspersed chroma worked out by hand with mirrored edges
  task t_video;
    video_out_pkg::pair_t e;
    int ly[$], cu[$], cv[$], p;
    ly = '{lin[0].y0, lin[0].y1, lin[1].y0, lin[1].y1};
    cu = '{lin[0].u, lin[1].u};
    cv = '{lin[0].v, lin[1].v};
    for (int m = 0; m < 7; m++) begin
      if (m == 3) continue;
      wreg(8'h00, 32'(m));
      send_line();
      for (int j = 0; j < (m > 3 ? 4 : 2); j++) begin
        e = m < 3 ? lin[j] : {8'(ly[j]), ip(ly, j), j[0] ? ip(cu, j / 2) : 8'(cu[j / 2]),
                              j[0] ? ip(cv, j / 2) : 8'(cv[j / 2])};
        p = m > 3 ? j : 2 * j; // Unscaled pair j has the taps of upscaled pair 2j
        if (m % 4 > 0) {e.u, e.v} = 16'(64'h9e30_7460_3ca0_12d0 >> (48 - 16 * p));
        take(e, 32'hffff_ffff);
      end
    end
  endtask : t_video

  // Coarse, fine, opaque with key bit alone, then key match over blend
  task t_overlay;
    video_out_pkg::pair_t e;
    wreg(8'h0c, 32'h0080_80c1);
    wreg(8'h10, 32'h0000_0011);
    wreg(8'h00, 32'h10);
    for (int c = 0; c < 4; c++) begin
      wreg(8'h04, 32'(enh_t[c]));
      wreg(8'h08, 32'(al_t[c]));
      send_line();
      for (int j = 0; j < 2; j++) begin
        e = lin[j];
        if (enh_t[c] != 3'h7) begin
          e.y0 = bl(lin[j].y0, ovl_data.y0, al_t[c][7:0], enh_t[c][0] & enh_t[c][1]);
          e.u  = bl(lin[j].u, ovl_data.u, al_t[c][7:0], enh_t[c][0] & enh_t[c][1]);
          e.v  = bl(lin[j].v, ovl_data.v, al_t[c][7:0], enh_t[c][0] & enh_t[c][1]);
          e.y1 = bl(lin[j].y1, ovl_data.y1, al_t[c][15:8], enh_t[c][0] & enh_t[c][1]);
        end
        take(e, 32'hffff_ffff);
      end
    end
  endtask : t_overlay

  task t_refuse;
    int hi;
    for (int m = 3; m < 16; m += 4) begin
      hi = 0;
      wreg(8'h00, 32'(m));
      repeat (2) @(posedge clk);
      in_valid <= 1'b1;
      repeat (8) begin
        @(negedge clk);
        hi += int'(in_ready !== 1'b0);
      end
      @(posedge clk);
      in_valid <= 1'b0;
      chk(32'(hi), 32'h0);
    end
    for (int m = 8; m < 10; m++) begin
      wreg(8'h00, 32'(m));
      raw_in       <= 8'(m) ^ 8'h5a;
      raw_in_valid <= 1'b1;
      @(posedge clk);
      raw_in_valid <= 1'b0;
      @(negedge clk);
      chk({raw_out_valid, raw_out}, {1'b1, 8'(m) ^ 8'h5a});
    end
  endtask : t_refuse

  // Main sequence
  initial begin
    {rst_n, wr, rd, in_valid, raw_in_valid, addr, wdata, raw_in} = '0;
    in_data   = '0;
    ovl_valid = 1'b1;
    ovl_data  = '{8'hc0, 8'hc0, 8'h80, 8'h81};
    lin[0]    = '{8'h10, 8'h20, 8'h90, 8'h40};
    lin[1]    = '{8'h30, 8'h60, 8'h20, 8'hc0};
    n_mismatch = 0;
    tests_run  = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_video();
    t_overlay();
    t_refuse();
    end_of_test();
  end
endmodule : test_video_out_pixel_processing
